/* File: rtl/self_diag_pkg.sv */
// Constants and types shared by the self-diagnostic block
package self_diag_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_RESULT = 8'h04;
  localparam logic [7:0] OFF_IRQ_ST = 8'h08;
  localparam logic [7:0] OFF_IRQ_MK = 8'h0c;
  localparam logic [7:0] OFF_COLOR  = 8'h40;
  localparam logic [7:0] OFF_COLEND = 8'h7c;
  localparam logic [7:0] OFF_NVRAM  = 8'h80;
  localparam logic [7:0] OFF_NVEND  = 8'hbc;
  // Diagnostic result bit positions and default
  localparam int         BIT_LOAD     = 7;
  localparam int         BIT_FUNC     = 6;
  localparam int         BIT_ATTACH   = 5;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  // Control register fields
  localparam int CTRL_SLEEP_OUT = 0;
  localparam int CTRL_TE_ON     = 1;
  localparam int CTRL_POWER_OK  = 2;
  localparam int CTRL_SOFT_RST  = 3;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_W    = 2;
  // Register set sizes
  localparam int         NREG        = 16;
  localparam int         NCOLOR      = 15;
  localparam int         COLOR_W     = 10;
  localparam logic [3:0] A_COLOR_LO  = 4'hc;
  localparam logic [7:0] CMD_USER_LO = 8'h00;
  localparam logic [7:0] CMD_USER_HI = 8'haf;
  localparam logic [7:0] CMD_ID_LO   = 8'hda;
  localparam logic [7:0] CMD_ID_HI   = 8'hdc;
  // Diagnostic validity windows
  localparam int CLK_HZ       = 20_000_000;
  localparam int SLEEP_WAIT_MS = 120;
  localparam int AWAKE_WAIT_MS = 5;
  localparam int SLEEP_WAIT_CYC = SLEEP_WAIT_MS * (CLK_HZ / 1000);
  localparam int AWAKE_WAIT_CYC = AWAKE_WAIT_MS * (CLK_HZ / 1000);
  localparam int WAIT_W = 22;
  typedef enum logic [2:0] {ST_IDLE, ST_COMPARE, ST_LOAD, ST_WAIT, ST_DONE} diag_state_t;
endpackage : self_diag_pkg

/* File: rtl/pin_sync.sv */
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys_in,
  input  wire logic         resetn_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule : pin_sync

/* File: rtl/wait_timer.sv */
// Down-counter that reports when a diagnostic wait has elapsed
`timescale 1ns/100ps
module wait_timer (
  // Clock and reset
  input  wire logic                               clk_sys_in,
  input  wire logic                               resetn_in,
  // Control
  input  wire logic                               start_in,
  input  wire logic [self_diag_pkg::WAIT_W-1:0]   load_in,
  output logic                                    done_out
);
  import self_diag_pkg::*;
  logic [WAIT_W-1:0] cnt_r;
  logic [WAIT_W-1:0] cnt_nxt;
  logic              done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (start_in) begin
      cnt_nxt = load_in;
    end else if (cnt_r != '0) begin
      cnt_nxt  = cnt_r - 1'b1;
      done_nxt = (cnt_r == WAIT_W'(1));
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r    <= '0;
      done_out <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      done_out <= done_nxt;
    end
  end
endmodule : wait_timer

/* File: rtl/sleep_out_self_diagnostic.sv */
// Sleep-out self-diagnostic with tearing-effect gating and pin quieting
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/100ps
module sleep_out_self_diagnostic #(
  parameter int SLEEP_WAIT = self_diag_pkg::SLEEP_WAIT_CYC,
  parameter int AWAKE_WAIT = self_diag_pkg::AWAKE_WAIT_CYC,
  parameter logic A_COLOR_USED = 1'b0
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Check results from analog and bump monitors
  input  wire logic        func_ok_in,
  input  wire logic        attach_ok_in,
  // Host interface pins
  input  wire logic        chip_select_n_in,
  input  wire logic        data_command_select_in,
  input  wire logic        write_strobe_n_in,
  input  wire logic        read_strobe_n_in,
  input  wire logic        line_sync_in,
  input  wire logic        frame_sync_in,
  input  wire logic        pixel_data_valid_in,
  input  wire logic [23:0] parallel_data_bus_in,
  // Gated pin inputs and output enables
  output logic [30:0]      host_pins_out,
  output logic             tearing_effect_output_out,
  output logic             pins_drive_en_out,
  output logic             irq_out
);
  import self_diag_pkg::*;

  localparam int PIN_W = 31;

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_CTRL) || (a == OFF_RESULT) || (a == OFF_IRQ_ST) ||
             (a == OFF_IRQ_MK) || in_range(a, OFF_COLOR, OFF_COLEND) ||
             in_range(a, OFF_NVRAM, OFF_NVEND);
  endfunction : mapped

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_sync;
  assign pins_raw = {chip_select_n_in, data_command_select_in, write_strobe_n_in,
                     read_strobe_n_in, line_sync_in, frame_sync_in,
                     pixel_data_valid_in, parallel_data_bus_in};

  pin_sync #(.W(PIN_W)) u_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (pins_raw),
    .sync_out   (pins_sync)
  );

  // State
  diag_state_t       state_r, state_nxt;
  logic [7:0]        result_r, result_nxt;
  logic              te_on_r, te_on_nxt;
  logic              te_fail_r, te_fail_nxt;
  logic              power_ok_r, power_ok_nxt;
  logic              soft_rst_r, soft_rst_nxt;
  logic              asleep_r, asleep_nxt;
  logic              match_r, match_nxt;
  logic [3:0]        idx_r, idx_nxt;
  logic [IRQ_W-1:0]  irq_st_r, irq_st_nxt;
  logic [IRQ_W-1:0]  irq_mk_r, irq_mk_nxt;
  logic [7:0]        nv_r [NREG];
  logic [7:0]        nv_nxt [NREG];
  logic [7:0]        reg_r [NREG];
  logic [7:0]        reg_nxt [NREG];
  logic [COLOR_W-1:0] color_r [NCOLOR];
  logic [COLOR_W-1:0] color_nxt [NCOLOR];
  logic [31:0]       prdata_nxt;
  logic              pslverr_nxt;
  logic [PIN_W-1:0]  host_pins_nxt;
  logic              te_out_nxt, drive_nxt, irq_nxt;
  logic              timer_start;
  logic [WAIT_W-1:0] timer_load;
  logic              timer_done;

  wait_timer u_timer (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .start_in   (timer_start),
    .load_in    (timer_load),
    .done_out   (timer_done)
  );

  // Reads and refusals decode in setup so they stand beside pready
  logic acc, setup, wr, rd;
  assign acc   = psel_in && penable_in;
  assign setup = psel_in && !penable_in;
  assign wr    = acc && pwrite_in;
  assign rd    = setup && !pwrite_in;

  always_comb begin
    state_nxt    = state_r;
    result_nxt   = result_r;
    te_on_nxt    = te_on_r;
    te_fail_nxt  = te_fail_r;
    power_ok_nxt = power_ok_r;
    soft_rst_nxt = 1'b0;
    asleep_nxt   = asleep_r;
    match_nxt    = match_r;
    idx_nxt      = idx_r;
    irq_st_nxt   = irq_st_r;
    irq_mk_nxt   = irq_mk_r;
    nv_nxt       = nv_r;
    reg_nxt      = reg_r;
    color_nxt    = color_r;
    timer_start  = 1'b0;
    timer_load   = '0;
    prdata_nxt   = '0;
    pslverr_nxt  = setup && !mapped(paddr_in);

    // Register writes; event sets below override these clears
    if (wr) begin
      if (paddr_in == OFF_CTRL) begin
        if (pwdata_in[CTRL_TE_ON]) begin
          te_on_nxt   = 1'b1;
          te_fail_nxt = 1'b0;
        end
        power_ok_nxt = pwdata_in[CTRL_POWER_OK];
        soft_rst_nxt = pwdata_in[CTRL_SOFT_RST];
        if (pwdata_in[CTRL_SLEEP_OUT] && state_r == ST_IDLE && power_ok_r) begin
          state_nxt = ST_COMPARE;
          idx_nxt   = '0;
          match_nxt = 1'b1;
        end
      end else if (paddr_in == OFF_IRQ_ST) begin
        irq_st_nxt = irq_st_r & ~pwdata_in[IRQ_W-1:0];
      end else if (paddr_in == OFF_IRQ_MK) begin
        irq_mk_nxt = pwdata_in[IRQ_W-1:0];
      end else if (in_range(paddr_in, OFF_COLOR, OFF_COLEND)) begin
        // Factory programming port for colour values
        if (paddr_in[5:2] < NCOLOR[3:0]) begin
          color_nxt[paddr_in[5:2]] = pwdata_in[COLOR_W-1:0];
        end
      end else if (in_range(paddr_in, OFF_NVRAM, OFF_NVEND)) begin
        nv_nxt[paddr_in[5:2]] = pwdata_in[7:0];
      end
    end

    if (rd) begin
      if (paddr_in == OFF_CTRL) begin
        prdata_nxt = {28'h0000000, 1'b0, power_ok_r, te_on_r, asleep_r};
      end else if (paddr_in == OFF_RESULT) begin
        prdata_nxt = {24'h000000, result_r};
      end else if (paddr_in == OFF_IRQ_ST) begin
        prdata_nxt = {30'h00000000, irq_st_r};
      end else if (paddr_in == OFF_IRQ_MK) begin
        prdata_nxt = {30'h00000000, irq_mk_r};
      end else if (in_range(paddr_in, OFF_COLOR, OFF_COLEND)) begin
        if (paddr_in[5:2] >= NCOLOR[3:0]) begin
          prdata_nxt = '0;
        end else if (!A_COLOR_USED && paddr_in[5:2] >= A_COLOR_LO) begin
          prdata_nxt = '0;
        end else begin
          prdata_nxt = {22'h000000, color_r[paddr_in[5:2]]};
        end
      end else if (in_range(paddr_in, OFF_NVRAM, OFF_NVEND)) begin
        prdata_nxt = {24'h000000, reg_r[paddr_in[5:2]]};
      end
    end

    case (state_r)
      ST_IDLE: begin
      end
      ST_COMPARE: begin
        // Index maps into the factory-only command space above AFh
        if (!in_range({4'hb, idx_r}, CMD_USER_LO, CMD_USER_HI) &&
            !in_range({4'hb, idx_r}, CMD_ID_LO, CMD_ID_HI)) begin
          if (reg_r[idx_r] != nv_r[idx_r]) begin
            match_nxt = 1'b0;
          end
        end
        idx_nxt = idx_r + 1'b1;
        if (idx_r == 4'hf) begin
          state_nxt = ST_LOAD;
        end
      end
      ST_LOAD: begin
        reg_nxt = nv_r;
        if (match_r) begin
          result_nxt[BIT_LOAD] = ~result_r[BIT_LOAD];
        end else begin
          te_fail_nxt = 1'b1;
        end
        if (attach_ok_in) begin
          result_nxt[BIT_ATTACH] = ~result_r[BIT_ATTACH];
        end else begin
          te_fail_nxt = 1'b1;
        end
        timer_start = 1'b1;
        timer_load  = asleep_r ? WAIT_W'(SLEEP_WAIT) : WAIT_W'(AWAKE_WAIT);
        asleep_nxt  = 1'b0;
        state_nxt   = ST_WAIT;
      end
      ST_WAIT: begin
        if (timer_done) begin
          if (func_ok_in) begin
            result_nxt[BIT_FUNC] = ~result_r[BIT_FUNC];
          end else begin
            te_fail_nxt = 1'b1;
          end
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        irq_st_nxt[IRQ_DONE] = 1'b1;
        if (te_fail_nxt) begin
          irq_st_nxt[IRQ_FAIL] = 1'b1;
        end
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase

    // Software reset returns the module to its sleep-in defaults
    if (soft_rst_r) begin
      state_nxt   = ST_IDLE;
      result_nxt  = RESULT_RESET;
      te_on_nxt   = 1'b0;
      te_fail_nxt = 1'b0;
      asleep_nxt  = 1'b1;
    end

    drive_nxt     = power_ok_r && !soft_rst_r;
    te_out_nxt    = drive_nxt && te_on_nxt && !te_fail_nxt;
    host_pins_nxt = drive_nxt ? pins_sync : '0;
    irq_nxt       = |(irq_st_nxt & irq_mk_nxt);
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r    <= ST_IDLE;
      result_r   <= RESULT_RESET;
      te_on_r    <= 1'b0;
      te_fail_r  <= 1'b0;
      power_ok_r <= 1'b0;
      soft_rst_r <= 1'b0;
      asleep_r   <= 1'b1;
      match_r    <= 1'b0;
      idx_r      <= '0;
      irq_st_r   <= '0;
      irq_mk_r   <= '0;
      for (int i = 0; i < NREG; i++) begin
        nv_r[i]  <= '0;
        reg_r[i] <= '0;
      end
      for (int i = 0; i < NCOLOR; i++) begin
        color_r[i] <= '0;
      end
      prdata_out                <= '0;
      pready_out                <= 1'b0;
      pslverr_out               <= 1'b0;
      host_pins_out             <= '0;
      tearing_effect_output_out <= 1'b0;
      pins_drive_en_out         <= 1'b0;
      irq_out                   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      result_r   <= result_nxt;
      te_on_r    <= te_on_nxt;
      te_fail_r  <= te_fail_nxt;
      power_ok_r <= power_ok_nxt;
      soft_rst_r <= soft_rst_nxt;
      asleep_r   <= asleep_nxt;
      match_r    <= match_nxt;
      idx_r      <= idx_nxt;
      irq_st_r   <= irq_st_nxt;
      irq_mk_r   <= irq_mk_nxt;
      nv_r       <= nv_nxt;
      reg_r      <= reg_nxt;
      color_r    <= color_nxt;
      prdata_out                <= prdata_nxt;
      pready_out                <= psel_in && !penable_in;
      pslverr_out               <= pslverr_nxt;
      host_pins_out             <= host_pins_nxt;
      tearing_effect_output_out <= te_out_nxt;
      pins_drive_en_out         <= drive_nxt;
      irq_out                   <= irq_nxt;
    end
  end
endmodule : sleep_out_self_diagnostic

/* File: testbench/self_diag_monitor.sv */
// Port-level assertions for the sleep-out self-diagnostic block
`timescale 1ns/100ps
module self_diag_monitor
  import self_diag_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        resetn_in,
  // Bus
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Pins
  input wire logic [30:0] host_pins_out,
  input wire logic        tearing_effect_output_out,
  input wire logic        pins_drive_en_out,
  input wire logic        irq_out
);
  logic [3:0] since_ctrl_r;
  logic [3:0] since_ctrl_nxt;

  // Cycles since the last control write, saturating
  always_comb begin
    since_ctrl_nxt = since_ctrl_r;
    if (psel_in && penable_in && pwrite_in && paddr_in == OFF_CTRL) begin
      since_ctrl_nxt = 4'h0;
    end else if (since_ctrl_r != 4'hf) begin
      since_ctrl_nxt = since_ctrl_r + 4'h1;
    end
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      since_ctrl_r <= 4'hf;
    end else begin
      since_ctrl_r <= since_ctrl_nxt;
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("pready held beyond one cycle");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside an access phase");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (psel_in && penable_in && paddr_in >= 8'hc0
    |-> pslverr_out && pready_out) else $error("unmapped access not refused");
  a_te_needs_drive: assert property (tearing_effect_output_out |-> pins_drive_en_out)
    else $error("tearing output high while pins quiet");
  a_pins_quiet: assert property (!pins_drive_en_out |-> host_pins_out == 31'h0)
    else $error("pin inputs passed while ignored");
  a_reset_quiet: assert property ($rose(resetn_in) |->
    !tearing_effect_output_out && !pins_drive_en_out && !irq_out)
    else $error("outputs active after reset");
  a_te_rise_cause: assert property ($rose(tearing_effect_output_out)
    |-> since_ctrl_r <= 4'h3) else $error("tearing output rose without control write");

  c_slverr: cover property (pslverr_out);
  c_te_rise: cover property ($rose(tearing_effect_output_out));
  c_irq_rise: cover property ($rose(irq_out));
endmodule : self_diag_monitor

bind sleep_out_self_diagnostic self_diag_monitor i_self_diag_monitor (
  .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .host_pins_out(host_pins_out),
  .tearing_effect_output_out(tearing_effect_output_out),
  .pins_drive_en_out(pins_drive_en_out), .irq_out(irq_out));

/* File: testbench/host_pin_model.sv */
// Host processor pin driver: steady word or a pattern changing every cycle
`timescale 1ns/100ps
module host_pin_model #(
  parameter logic [30:0] PATTERN = 31'h0
) (
  // Clock and control
  input  wire logic        clk_sys_in,
  input  wire logic        hold_in,
  // Pins
  output logic      [30:0] pins_out
);
  logic [30:0] cnt_r = 31'h0;

  always @(posedge clk_sys_in) begin
    cnt_r <= cnt_r + 31'h1;
  end
  // Steady word lets the bench predict the synced pins
  assign pins_out = hold_in ? PATTERN : cnt_r;
endmodule : host_pin_model

/* File: testbench/sleep_out_self_diagnostic_bench.sv */
// Self-checking bench for the sleep-out self-diagnostic block
`timescale 1ns/100ps
module sleep_out_self_diagnostic_bench;
  import self_diag_pkg::*;
  localparam int SW = 20;
  localparam int AW = 10;
  localparam logic [30:0] PAT = 31'h2a5c3e91;
  logic clk_sys_in = 1'b0, resetn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, func_ok_in = 1'b1, attach_ok_in = 1'b1, hold_pat = 1'b1;
  logic [7:0] paddr_in = 8'h00, base;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rq;
  logic pready_out, pslverr_out, te, drv_en, irq_out, er;
  logic [30:0] host_drv, host_pins_out;
  int bad_count = 0, cmp_count = 0, tick = 0, n1, n2;

  always #25 clk_sys_in = ~clk_sys_in;

  host_pin_model #(.PATTERN(PAT)) i_host_pin_model (.clk_sys_in(clk_sys_in),
    .hold_in(hold_pat), .pins_out(host_drv));
  sleep_out_self_diagnostic #(.SLEEP_WAIT(SW), .AWAKE_WAIT(AW), .A_COLOR_USED(1'b0))
    i_sleep_out_self_diagnostic (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .func_ok_in(func_ok_in),
    .attach_ok_in(attach_ok_in), .chip_select_n_in(host_drv[30]),
    .data_command_select_in(host_drv[29]), .write_strobe_n_in(host_drv[28]),
    .read_strobe_n_in(host_drv[27]), .line_sync_in(host_drv[26]),
    .frame_sync_in(host_drv[25]), .pixel_data_valid_in(host_drv[24]),
    .parallel_data_bus_in(host_drv[23:0]), .host_pins_out(host_pins_out),
    .tearing_effect_output_out(te), .pins_drive_en_out(drv_en), .irq_out(irq_out));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Holds the request until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1 && n < 20) begin
      @(posedge clk_sys_in);
      n++;
    end
    rq = prdata_out;
    er = pslverr_out;
    if (pready_out !== 1'b1) bad_count++;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task settle;
    repeat (3) @(negedge clk_sys_in);
  endtask : settle

  // Sleep-out, then count cycles until the done interrupt
  task run_diag(output int n);
    n = 0;
    apb(1'b1, OFF_CTRL, 32'h7);
    while (irq_out !== 1'b1 && n < 400) begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 400) bad_count++;
  endtask : run_diag

  task t_reset;
    apb(1'b0, OFF_RESULT, 32'h0);
    chk("result_rst", rq, {24'h0, RESULT_RESET});
    apb(1'b0, 8'hf0, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    $display("test reset done");
  endtask : t_reset

  task t_pins;
    settle();
    chk("pins_off", {1'b0, host_pins_out}, 32'h0);
    chk("drv_off", {31'h0, drv_en}, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h6);
    settle();
    chk("pins_on", {1'b0, host_pins_out}, {1'b0, PAT});
    chk("drv_on", {31'h0, drv_en}, 32'h1);
    chk("te_on", {31'h0, te}, 32'h1);
    @(posedge clk_sys_in) hold_pat <= 1'b0;
    $display("test pins done");
  endtask : t_pins

  task t_diag_pass;
    apb(1'b1, OFF_IRQ_MK, 32'h1);
    run_diag(n1);
    apb(1'b1, OFF_IRQ_ST, 32'h3);
    apb(1'b1, OFF_CTRL, 32'h6);
    apb(1'b0, OFF_RESULT, 32'h0);
    base = rq[7:0];
    run_diag(n2);
    apb(1'b1, OFF_IRQ_ST, 32'h3);
    apb(1'b0, OFF_RESULT, 32'h0);
    chk("result_pass", rq, {24'h0, base ^ 8'he0});
    chk("wait_diff", 32'(n1 - n2), 32'(SW - AW));
    $display("test diag pass done");
  endtask : t_diag_pass

  task t_diag_fail;
    apb(1'b1, OFF_NVRAM, 32'h155);
    @(posedge clk_sys_in) func_ok_in <= 1'b0;
    attach_ok_in <= 1'b0;
    run_diag(n1);
    apb(1'b0, OFF_RESULT, 32'h0);
    chk("result_fail", rq, {24'h0, base ^ 8'he0});
    chk("te_fail", {31'h0, te}, 32'h0);
    apb(1'b0, OFF_NVRAM, 32'h0);
    chk("reg_loaded", rq, 32'h55);
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    chk("irq_status", rq, 32'h3);
    apb(1'b1, OFF_IRQ_ST, 32'h1);
    apb(1'b1, OFF_IRQ_MK, 32'h2);
    settle();
    chk("irq_fail", {31'h0, irq_out}, 32'h1);
    apb(1'b1, OFF_IRQ_MK, 32'h0);
    settle();
    chk("irq_masked", {31'h0, irq_out}, 32'h0);
    apb(1'b1, OFF_IRQ_ST, 32'h2);
    apb(1'b0, OFF_IRQ_ST, 32'h0);
    chk("irq_clear", rq, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h6);
    settle();
    chk("te_again", {31'h0, te}, 32'h1);
    @(posedge clk_sys_in) func_ok_in <= 1'b1;
    attach_ok_in <= 1'b1;
    $display("test diag fail done");
  endtask : t_diag_fail

  task t_colour;
    apb(1'b1, 8'h54, 32'h28f);
    apb(1'b1, 8'h6c, 32'h140);
    apb(1'b1, 8'h70, 32'h3ff);
    apb(1'b0, 8'h54, 32'h0);
    chk("colour_frac", rq, 32'h28f);
    apb(1'b0, 8'h6c, 32'h0);
    chk("colour_blue", rq, 32'h140);
    apb(1'b0, 8'h70, 32'h0);
    chk("colour_unused", rq, 32'h0);
    $display("test colour done");
  endtask : t_colour

  task t_soft;
    apb(1'b1, OFF_IRQ_MK, 32'h1);
    run_diag(n1);
    apb(1'b1, OFF_IRQ_ST, 32'h3);
    apb(1'b0, OFF_RESULT, 32'h0);
    chk("result_hold", rq, {24'h0, base});
    apb(1'b1, OFF_CTRL, 32'hc);
    settle();
    apb(1'b0, OFF_RESULT, 32'h0);
    chk("result_soft", rq, {24'h0, RESULT_RESET});
    chk("te_soft", {31'h0, te}, 32'h0);
    $display("test soft reset done");
  endtask : t_soft

  task final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  always @(posedge clk_sys_in) begin
    tick++;
    if (tick == 6000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    t_reset();
    t_pins();
    t_diag_pass();
    t_diag_fail();
    t_colour();
    t_soft();
    final_report();
  end
endmodule : sleep_out_self_diagnostic_bench
